// ==== rtl/sccfg_top.sv ====
// Card protocol and clock configuration block with APB register access
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
// Contract
// - Aux line driven when its direction bit is 0, input when 1; bit3 second, bit2 first.
// - After reset aux drivers are off and the direction register is zero.
// - Internal sync mode routes reset, data, aux lines to firmware bits; clock from divider.
// - Nine-bit sync: first eight bits form a byte, ninth goes to receive control.
// - External sync mode routes external data line to firmware bits; clock from divider.
// - Protocol select 0 means character protocol, 1 means block protocol.
// - Check logic runs only in block protocol with the enable set.
// - Computed check value is appended after the last transmit byte.
// - Check value over received bytes is readable as low and high byte.
// - Type select 1 picks CRC, 0 picks LRC.
// - Answer-to-reset timeout runs while the enable bit is 1.
// - Master clock divided by field plus one, then by two, gives the card clock.
// - Internal divider register resets to ratio thirteen.
// - New divider values load only at a half-period boundary, glitch free.
// - Divider field zero acts as one.
// - Separate external clock divider register with the same reset.
// - Sync mode captures the data line on each rising card clock edge.
module sccfg_top
   import sccfg_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             card_rst_o,
   output logic             card_clk_o,
   input  wire logic        card_data_i,
   output logic             card_data_o,
   output logic             card_data_oe,
   input  wire logic        first_aux_i,
   output logic             first_aux_o,
   output logic             first_aux_oe,
   input  wire logic        second_aux_i,
   output logic             second_aux_o,
   output logic             second_aux_oe,
   output logic             ext_clk_o,
   input  wire logic        ext_data_i,
   output logic             ext_data_o,
   output logic             ext_data_oe,
   output sccfg_mode_t      mode_o,
   output logic             check_active_o,
   output logic             atr_timeout_o,
   output sccfg_byte_t      rx_byte_o,
   output sccfg_byte_t      tx_byte_o
);
   import sccfg_pkg::*;

   // Register state
   logic [7:0]  dir_r, proto_r, iclk_r, eclk_r, ictl_r, ectl_r, rxctl_r, irq_st_r, irq_en_r;
   logic [15:0] chk_r;
   logic [15:0] atr_cnt_r;
   logic        atr_to_r;
   logic        dir_set_r;    // Aux drivers stay released until software sets a direction

   // CRC-16 step of one byte; shared by receive and transmit paths
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         if (x[15] ^ d[i]) begin
            x = {x[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            x = {x[14:0], 1'b0};
         end
      end
      return x;
   endfunction

   // Effective divide count; zero behaves as one
   function automatic logic [5:0] eff_div(input logic [7:0] f);
      return (f[5:0] == 6'h00) ? 6'h01 : f[5:0];
   endfunction

   // APB decode: zero-wait slave, unmapped addresses answer with pslverr
   logic        acc, wr, rd;
   logic [15:0] idx;
   logic        hit;
   assign idx = paddr[17:2];
   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;
   assign pready = 1'b1;
   always_comb begin
      hit = 1'b1;
      case (idx)
         IDX_DIR, IDX_PROTO, IDX_ICLK, IDX_ECLK, IDX_ICTL, IDX_ECTL, IDX_RXCTL,
         IDX_CHK, IDX_IRQ_ST, IDX_IRQ_EN, IDX_IRQ_CLR, IDX_TXDATA: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = acc & ~hit;

   // Pin synchronisers: two flops before any logic reads a pin
   logic [3:0] pin_s1_r, pin_s2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
      end else begin
         pin_s1_r <= {ext_data_i, second_aux_i, first_aux_i, card_data_i};
         pin_s2_r <= pin_s1_r;
      end
   end

   // Configuration registers; reserved protocol bit 4 is forced to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r   <= RST_DIR;
         dir_set_r <= 1'b0;
         proto_r <= RST_PROTO;
         iclk_r  <= RST_CLK;
         eclk_r  <= RST_CLK;
         ictl_r  <= 8'h10;
         ectl_r  <= 8'h10;
         irq_en_r <= 8'h00;
      end else if (wr) begin
         if (idx == IDX_DIR) dir_set_r <= 1'b1;
         case (idx)
            IDX_DIR:    dir_r    <= pwdata[7:0] & 8'h0C;
            IDX_PROTO:  proto_r  <= pwdata[7:0] & ~(8'h01 << B_RSVD);
            IDX_ICLK:   iclk_r   <= {2'b00, pwdata[5:0]};
            IDX_ECLK:   eclk_r   <= {2'b00, pwdata[5:0]};
            IDX_ICTL:   ictl_r   <= pwdata[7:0];
            IDX_ECTL:   ectl_r   <= pwdata[7:0];
            IDX_IRQ_EN: irq_en_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   assign mode_o = '{isync: proto_r[B_ISYNC], nine: proto_r[B_NINE], esync: proto_r[B_ESYNC],
                     protocol_select: proto_r[B_PROTOCOL_SELECT], chk_en: proto_r[B_CHKEN],
                     chk_crc: proto_r[B_CHKTYPE], atr_en: proto_r[B_ATR]};
   // Check only in block protocol; character protocol ignores the enable
   assign check_active_o = mode_o.protocol_select & mode_o.chk_en;

   // Clock dividers: a shadow divisor loads only when the count wraps, so a write
   // mid-period never shortens a half cycle of the card clock
   logic [5:0] icnt_r, ecnt_r, idiv_r, ediv_r;
   logic       itick, etick, iclk_q_r, eclk_q_r;
   assign itick = (icnt_r == idiv_r);
   assign etick = (ecnt_r == ediv_r);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         icnt_r   <= 6'h00;
         ecnt_r   <= 6'h00;
         idiv_r   <= RST_CLK[5:0];
         ediv_r   <= RST_CLK[5:0];
         iclk_q_r <= 1'b0;
         eclk_q_r <= 1'b0;
      end else begin
         icnt_r <= itick ? 6'h00 : icnt_r + 6'h01;
         ecnt_r <= etick ? 6'h00 : ecnt_r + 6'h01;
         if (itick) begin
            idiv_r   <= eff_div(iclk_r);
            iclk_q_r <= ~iclk_q_r;
         end
         if (etick) begin
            ediv_r   <= eff_div(eclk_r);
            eclk_q_r <= ~eclk_q_r;
         end
      end
   end
   // Clock off (bit 0) parks at level (bit 1)
   assign card_clk_o = ictl_r[0] ? ictl_r[1] : iclk_q_r;
   assign ext_clk_o  = ectl_r[0] ? ectl_r[1] : eclk_q_r;
   logic i_rise, e_rise;
   assign i_rise = itick & ~iclk_q_r & ~ictl_r[0];
   assign e_rise = etick & ~eclk_q_r & ~ectl_r[0];

   // Pin drivers: aux lines follow direction register, data from firmware in sync mode
   assign card_rst_o    = mode_o.isync & ictl_r[B_CTL_RST];
   assign first_aux_o   = ictl_r[B_FIRST_DIR];
   assign second_aux_o  = ictl_r[B_SECOND_DIR];
   assign first_aux_oe  = dir_set_r & ~dir_r[B_FIRST_DIR];
   assign second_aux_oe = dir_set_r & ~dir_r[B_SECOND_DIR];
   assign card_data_o   = ictl_r[B_CTL_DATA];
   assign card_data_oe  = mode_o.isync & ~ictl_r[B_CTL_DDIR];
   assign ext_data_o    = ectl_r[B_CTL_DATA];
   assign ext_data_oe   = mode_o.esync & ~ectl_r[B_CTL_DDIR];

   // Sync receive: sample data on rising card clock, shift bytes, ninth bit aside
   logic [7:0] sh_r;
   logic [3:0] bit_r;
   logic       smp_bit, smp_go, byte_done, ninth_done;
   logic       ilatch_r, elatch_r;
   assign smp_go  = (mode_o.isync & i_rise) | (mode_o.esync & ~mode_o.isync & e_rise);
   assign smp_bit = mode_o.isync ? pin_s2_r[0] : pin_s2_r[3];
   assign byte_done  = smp_go & (bit_r == 4'd7);
   assign ninth_done = smp_go & (bit_r == 4'd8);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_r      <= 8'h00;
         bit_r     <= 4'h0;
         rx_byte_o <= '0;
         rxctl_r   <= 8'h00;
         ilatch_r  <= 1'b0;
         elatch_r  <= 1'b0;
      end else begin
         rx_byte_o.valid <= 1'b0;
         if (mode_o.isync & i_rise) ilatch_r <= pin_s2_r[0];
         if (mode_o.esync & e_rise) elatch_r <= pin_s2_r[3];
         if (smp_go) begin
            sh_r <= {smp_bit, sh_r[7:1]};
            if (bit_r == 4'd7) begin
               rx_byte_o <= '{data: {smp_bit, sh_r[7:1]}, valid: 1'b1};
               bit_r     <= mode_o.nine ? 4'd8 : 4'd0;
            end else if (bit_r == 4'd8) begin
               rxctl_r[B_CTL_DATA] <= smp_bit;
               bit_r <= 4'd0;
            end else begin
               bit_r <= bit_r + 4'd1;
            end
         end
      end
   end

   // Check value over received bytes, CRC or LRC; software write to CHK reseeds
   logic [7:0] tx_q_r;
   logic [1:0] tx_st_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chk_r <= CRC_INIT;
      end else if (wr && idx == IDX_CHK) begin
         chk_r <= mode_o.chk_crc ? CRC_INIT : 16'h0000;
      end else if (check_active_o && (rx_byte_o.valid || (wr && idx == IDX_TXDATA))) begin
         if (mode_o.chk_crc)
            chk_r <= crc_byte(chk_r, rx_byte_o.valid ? rx_byte_o.data : pwdata[7:0]);
         else
            chk_r <= {8'h00, chk_r[7:0] ^ (rx_byte_o.valid ? rx_byte_o.data : pwdata[7:0])};
      end
   end

   // Transmit stream: pwdata[8] marks the last byte; check bytes follow it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_byte_o <= '0;
         tx_st_r   <= 2'd0;
         tx_q_r    <= 8'h00;
      end else begin
         tx_byte_o.valid <= 1'b0;
         if (wr && idx == IDX_TXDATA) begin
            tx_byte_o <= '{data: pwdata[7:0], valid: 1'b1};
            if (pwdata[8] && check_active_o) tx_st_r <= mode_o.chk_crc ? 2'd2 : 2'd1;
         end else if (tx_st_r == 2'd2) begin
            tx_byte_o <= '{data: chk_r[15:8], valid: 1'b1};
            tx_st_r   <= 2'd1;
         end else if (tx_st_r == 2'd1) begin
            tx_byte_o <= '{data: chk_r[7:0], valid: 1'b1};
            tx_st_r   <= 2'd0;
         end
      end
   end

   // Answer-to-reset timeout counts card clocks while enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         atr_cnt_r <= 16'h0000;
         atr_to_r  <= 1'b0;
      end else if (!mode_o.atr_en) begin
         atr_cnt_r <= 16'h0000;
         atr_to_r  <= 1'b0;
      end else if (i_rise && !atr_to_r) begin
         atr_cnt_r <= atr_cnt_r + 16'h0001;
         atr_to_r  <= (atr_cnt_r == ATR_CLKS - 16'h0001);
      end
   end
   assign atr_timeout_o = atr_to_r;

   // Sticky interrupt status; a new event wins over a same-cycle clear
   logic [7:0] ev;
   assign ev = {5'h00, (tx_st_r == 2'd1), ninth_done, byte_done};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_r <= 8'h00;
      end else begin
         irq_st_r <= (irq_st_r & ~((wr && idx == IDX_IRQ_CLR) ? pwdata[7:0] : 8'h00)) | ev;
      end
   end
   assign irq = |(irq_st_r & irq_en_r);

   // Read mux; aux pins read live value when configured as inputs
   always_comb begin
      prdata = 32'h0000_0000;
      case (idx)
         IDX_DIR:    prdata[7:0] = dir_r;
         IDX_PROTO:  prdata[7:0] = proto_r;
         IDX_ICLK:   prdata[7:0] = iclk_r;
         IDX_ECLK:   prdata[7:0] = eclk_r;
         IDX_ICTL:   prdata[7:0] = {ictl_r[7:6], mode_o.isync ? ilatch_r : pin_s2_r[0], ictl_r[4],
                                    dir_r[3] ? pin_s2_r[2] : ictl_r[3],
                                    dir_r[2] ? pin_s2_r[1] : ictl_r[2], ictl_r[1:0]};
         IDX_ECTL:   prdata[7:0] = {ectl_r[7:6], mode_o.esync ? elatch_r : pin_s2_r[3], ectl_r[4:0]};
         IDX_RXCTL:  prdata[7:0] = rxctl_r;
         IDX_CHK:    prdata[15:0] = chk_r;
         IDX_IRQ_ST: prdata[7:0] = irq_st_r;
         IDX_IRQ_EN: prdata[7:0] = irq_en_r;
         default:    prdata = 32'h0000_0000;
      endcase
      if (!rd) prdata = 32'h0000_0000;
   end

   // Assertions
   a_dir_drive: assert property (@(posedge pclk) disable iff (!presetn)
      first_aux_oe == (dir_set_r & ~dir_r[2]) && second_aux_oe == (dir_set_r & ~dir_r[3]))
      else $error("aux enable mismatch");
   a_proto_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
      proto_r[4] == 1'b0) else $error("reserved protocol bit set");
   a_chk_gate: assert property (@(posedge pclk) disable iff (!presetn)
      check_active_o |-> mode_o.protocol_select) else $error("check active outside block protocol");
   a_div_zero: assert property (@(posedge pclk) disable iff (!presetn)
      idiv_r != 6'h00) else $error("divisor zero");
   a_div_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !itick |=> $stable(idiv_r)) else $error("divisor changed mid period");
   a_clk_half: assert property (@(posedge pclk) disable iff (!presetn)
      itick |=> iclk_q_r != $past(iclk_q_r)) else $error("card clock did not toggle");
   a_atr_off: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_o.atr_en |=> !atr_to_r) else $error("timeout while disabled");
   a_tx_append: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_st_r == 2'd1) |=> tx_byte_o.valid && tx_byte_o.data == $past(chk_r[7:0]))
      else $error("check byte not appended");
endmodule

// ==== rtl/sccfg_pkg.sv ====
// Package: register map, field positions, resets and carriers for the card config block
package sccfg_pkg;
   // Word indices, byte address over four (printed offsets are multiples of four only partly, so indices)
   localparam logic [15:0] IDX_DIR      = 16'hFE0C;
   localparam logic [15:0] IDX_PROTO    = 16'hFE0D;
   localparam logic [15:0] IDX_ICLK     = 16'hFE0F;
   localparam logic [15:0] IDX_ECLK     = 16'hFE10;
   localparam logic [15:0] IDX_ICTL     = 16'hFE20;
   localparam logic [15:0] IDX_ECTL     = 16'hFE21;
   localparam logic [15:0] IDX_RXCTL    = 16'hFE22;
   localparam logic [15:0] IDX_CHK      = 16'hFE23;
   localparam logic [15:0] IDX_IRQ_ST   = 16'hFE24;
   localparam logic [15:0] IDX_IRQ_EN   = 16'hFE25;
   localparam logic [15:0] IDX_IRQ_CLR  = 16'hFE26;
   localparam logic [15:0] IDX_TXDATA   = 16'hFE27;
   // Reset values
   localparam logic [7:0]  RST_DIR      = 8'h00;
   localparam logic [7:0]  RST_PROTO    = 8'h03;
   localparam logic [7:0]  RST_CLK      = 8'h0C;
   // Field positions
   localparam int          B_SECOND_DIR = 3;
   localparam int          B_FIRST_DIR  = 2;
   localparam int          B_ISYNC      = 7;
   localparam int          B_NINE       = 6;
   localparam int          B_ESYNC      = 5;
   localparam int          B_RSVD       = 4;
   localparam int          B_PROTOCOL_SELECT      = 3;
   localparam int          B_CHKEN      = 2;
   localparam int          B_CHKTYPE    = 1;
   localparam int          B_ATR        = 0;
   // Internal control bits: data 5, data dir 4, second aux 3, first aux 2, reset 1
   localparam int          B_CTL_DATA   = 5;
   localparam int          B_CTL_DDIR   = 4;
   localparam int          B_CTL_RST    = 1;
   // Interrupt bits
   localparam int          I_RXBYTE     = 0;
   localparam int          I_NINTH      = 1;
   localparam int          I_CHKDONE    = 2;
   // ATR timeout in card clocks (plain default)
   localparam logic [15:0] ATR_CLKS     = 16'h9C40;
   localparam logic [15:0] CRC_POLY     = 16'h1021;
   localparam logic [15:0] CRC_INIT     = 16'hFFFF;

   typedef struct packed {
      logic       isync;
      logic       nine;
      logic       esync;
      logic       protocol_select;
      logic       chk_en;
      logic       chk_crc;
      logic       atr_en;
   } sccfg_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic       valid;
   } sccfg_byte_t;
endpackage

// ==== verif/sccfg_card_model.sv ====
// Behavioural smart card contact model driving one data line from the card clock
`timescale 1ns/1ns
module sccfg_card_model (
   input  wire logic card_clk,
   input  wire logic active,
   input  wire logic send_level,
   output logic      data_o,
   output logic      data_oe
);
   // Data changes after the falling edge, so it is steady at the sampling rise
   initial begin
      data_o = 1'b0;
   end
   always @(negedge card_clk) begin
      data_o <= send_level;
   end
   // Releasing is immediate; the bench pull-up then owns the wire
   assign data_oe = active;
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the card protocol and clock configuration block
`timescale 1ns/1ns
module tb;
   import sccfg_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        card_rst_o, card_clk_o, card_data_i, card_data_o, card_data_oe, ext_clk_o;
   logic        first_aux_i, first_aux_o, first_aux_oe, second_aux_i, second_aux_o, second_aux_oe;
   logic        ext_data_i, ext_data_o, ext_data_oe, check_active_o, atr_timeout_o;
   logic        cm_o, cm_oe, em_o, em_oe, card_lvl, card_act, ext_lvl, ext_act;
   sccfg_mode_t mode_o;
   sccfg_byte_t rx_byte_o, tx_byte_o;
   logic [7:0]  txq [$];
   int          miscompares, compares;
   sccfg_top i_sccfg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .card_rst_o(card_rst_o), .card_clk_o(card_clk_o), .card_data_i(card_data_i), .card_data_o(card_data_o),
      .card_data_oe(card_data_oe), .first_aux_i(first_aux_i), .first_aux_o(first_aux_o),
      .first_aux_oe(first_aux_oe), .second_aux_i(second_aux_i), .second_aux_o(second_aux_o),
      .second_aux_oe(second_aux_oe), .ext_clk_o(ext_clk_o), .ext_data_i(ext_data_i), .ext_data_o(ext_data_o),
      .ext_data_oe(ext_data_oe), .mode_o(mode_o), .check_active_o(check_active_o),
      .atr_timeout_o(atr_timeout_o), .rx_byte_o(rx_byte_o), .tx_byte_o(tx_byte_o));
   sccfg_card_model i_sccfg_card_model (.card_clk(card_clk_o), .active(card_act), .send_level(card_lvl),
      .data_o(cm_o), .data_oe(cm_oe));
   sccfg_card_model i_sccfg_ext_model (.card_clk(ext_clk_o), .active(ext_act), .send_level(ext_lvl),
      .data_o(em_o), .data_oe(em_oe));
   // Wire levels: whoever enables drives, otherwise the pull-up wins
   assign card_data_i  = card_data_oe ? card_data_o : (cm_oe ? cm_o : 1'b1);
   assign ext_data_i   = ext_data_oe ? ext_data_o : (em_oe ? em_o : 1'b1);
   assign first_aux_i  = first_aux_oe ? first_aux_o : 1'b1;
   assign second_aux_i = second_aux_oe ? second_aux_o : 1'b1;
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Collect every byte the block hands to the transmitter
   always @(posedge pclk) begin
      if (tx_byte_o.valid === 1'b1) txq.push_back(tx_byte_o.data);
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check("pready", 32'h1, 32'h0);
      rd = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      apb(1'b1, idx, d, rd);
   endtask
   task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] rd;
      apb(1'b0, idx, 32'h0, rd);
      check(what, exp, rd & m);
   endtask
   function automatic logic cur(input bit ext);
      return ext ? ext_clk_o : card_clk_o;
   endfunction
   // Four consecutive whole stretches at one level of a card clock, in pclk cycles
   task automatic halves(input bit ext, output int h [4]);
      logic lv;
      int   n;
      @(negedge pclk);
      lv = cur(ext);
      n = 0;
      while (cur(ext) === lv && n < 400) begin
         @(negedge pclk);
         n++;
      end
      for (int i = 0; i < 4; i++) begin
         lv = cur(ext);
         h[i] = 0;
         while (cur(ext) === lv && h[i] < 400) begin
            @(negedge pclk);
            h[i]++;
         end
      end
   endtask
   task automatic t_reset;
      check("aux released after reset", 32'h0, {first_aux_oe, second_aux_oe});
      rd_chk("direction reset", IDX_DIR, 32'h00, 32'hFF);
      rd_chk("protocol reset", IDX_PROTO, 32'h03, 32'hFF);
      rd_chk("internal divider reset", IDX_ICLK, 32'h0C, 32'hFF);
      rd_chk("external divider reset", IDX_ECLK, 32'h0C, 32'hFF);
      rd_chk("unmapped read", 16'h0001, 32'h0, 32'hFFFFFFFF);
      check("unmapped error", 32'h1, last_err);
      wr(IDX_DIR, 32'h0C);
      wr(IDX_PROTO, 32'h2E);
      wr(IDX_ECLK, 32'h3F);
      rd_chk("direction rw", IDX_DIR, 32'h0C, 32'hFF);
      rd_chk("protocol rw", IDX_PROTO, 32'h2E, 32'hFF);
      rd_chk("external divider rw", IDX_ECLK, 32'h3F, 32'hFF);
   endtask
   // Every protocol, check enable and check type combination
   task automatic t_mode;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         wr(IDX_PROTO, {28'h0, c, 1'b0});
         @(negedge pclk);
         check("check active", {31'h0, c[2] & c[1]}, check_active_o);
         check("protocol select", {31'h0, c[2]}, mode_o.protocol_select);
         check("check type", {31'h0, c[0]}, mode_o.chk_crc);
      end
   endtask
   task automatic t_aux;
      wr(IDX_PROTO, 32'h80);
      wr(IDX_ICTL, 32'h1F);
      wr(IDX_DIR, 32'h08);
      @(negedge pclk);
      check("first aux oe", 32'h1, first_aux_oe);
      check("second aux oe", 32'h0, second_aux_oe);
      check("first aux level", 32'h1, first_aux_o);
      check("card reset", 32'h1, card_rst_o);
      wr(IDX_DIR, 32'h04);
      @(negedge pclk);
      check("first aux oe", 32'h0, first_aux_oe);
      check("second aux oe", 32'h1, second_aux_oe);
      check("second aux level", 32'h1, second_aux_o);
   endtask
   // Divider steps, including zero and the widest field, changed while running
   task automatic t_divider(input bit ext);
      logic [7:0] f [5] = '{8'h0C, 8'h00, 8'h01, 8'h03, 8'h3F};
      int         h [4];
      int         old_half, new_half;
      wr(IDX_PROTO, ext ? 32'h20 : 32'h80);
      wr(ext ? IDX_ECTL : IDX_ICTL, 32'h10);
      old_half = 13;
      for (int i = 0; i < 5; i++) begin
         wr(ext ? IDX_ECLK : IDX_ICLK, {24'h0, f[i]});
         new_half = (f[i] == 8'h00) ? 2 : int'(f[i]) + 1;
         halves(ext, h);
         foreach (h[j]) if (h[j] != old_half && h[j] != new_half) check("glitch free half", new_half, h[j]);
         halves(ext, h);
         check("card clock half period", new_half, h[3]);
         old_half = new_half;
      end
   endtask
   // Sync mode capture with the card holding its line, plus interrupt handling
   task automatic t_sync_rx;
      logic l;
      int   n;
      wr(IDX_PROTO, 32'hC0);
      wr(IDX_ICLK, 32'h00);
      wr(IDX_IRQ_CLR, 32'h07);
      wr(IDX_IRQ_EN, 32'h03);
      for (int k = 1; k >= 0; k--) begin
         l = k[0];
         card_lvl <= l;
         card_act <= 1'b1;
         wr(IDX_ICTL, 32'h10);
         for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
               @(negedge pclk);
               n++;
            end while (rx_byte_o.valid !== 1'b1 && n < 400);
         end
         check("received byte", {24'h0, {8{l}}}, rx_byte_o.data);
         wr(IDX_ICTL, 32'h11);
         rd_chk("ninth bit", IDX_RXCTL, {26'h0, l, 5'h0}, 32'h20);
         rd_chk("captured data", IDX_ICTL, {26'h0, l, 5'h0}, 32'h20);
         if (l) begin
            rd_chk("irq status", IDX_IRQ_ST, 32'h3, 32'h3);
            check("irq raised", 32'h1, irq);
            wr(IDX_IRQ_EN, 32'h00);
            @(negedge pclk);
            check("irq masked", 32'h0, irq);
            wr(IDX_IRQ_EN, 32'h03);
            wr(IDX_IRQ_CLR, 32'h03);
            rd_chk("irq cleared", IDX_IRQ_ST, 32'h0, 32'h3);
            check("irq low", 32'h0, irq);
         end
      end
      card_act <= 1'b0;
   endtask
   task automatic t_ext_sync;
      int h [4];
      wr(IDX_PROTO, 32'h20);
      wr(IDX_ECTL, 32'h10);
      for (int k = 1; k >= 0; k--) begin
         ext_lvl <= k[0];
         ext_act <= 1'b1;
         halves(1'b1, h);
         rd_chk("external captured data", IDX_ECTL, {26'h0, k[0], 5'h0}, 32'h20);
      end
      ext_act <= 1'b0;
   endtask
   // Three transmit bytes; check bytes follow only in block protocol with checking on
   task automatic t_tx(input logic [7:0] proto, input int exp_n, input logic [7:0] lrc);
      logic [31:0] d [3] = '{32'h012, 32'h034, 32'h156};
      int          n;
      wr(IDX_PROTO, {24'h0, proto});
      wr(IDX_CHK, 32'h0);
      txq.delete();
      foreach (d[i]) wr(IDX_TXDATA, d[i]);
      n = 0;
      while (txq.size() < exp_n && n < 2000) begin
         @(negedge pclk);
         n++;
      end
      repeat (200) @(negedge pclk);
      check("transmit count", exp_n, txq.size());
      check("answer timeout idle", 32'h0, atr_timeout_o);
      if (txq.size() > 2) check("last data byte", 32'h56, txq[2]);
      if (exp_n == 4) check("appended LRC", {24'h0, lrc}, txq[3]);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog sized well beyond the expected run length
   initial begin
      repeat (100000) @(posedge pclk);
      miscompares++;
      final_report;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {card_lvl, card_act, ext_lvl, ext_act, last_err} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_mode;
      t_aux;
      t_divider(1'b0);
      t_divider(1'b1);
      t_sync_rx;
      t_ext_sync;
      t_tx(8'h0C, 4, 8'h70);
      t_tx(8'h0E, 5, 8'h00);
      t_tx(8'h04, 3, 8'h00);
      t_tx(8'h08, 3, 8'h00);
      final_report;
   end
endmodule
